// >>> core/eg_pkg.sv
package eg_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PPR  = 8'h04;
   localparam logic [7:0] OFS_GNUM = 8'h08;
   localparam logic [7:0] OFS_GDEN = 8'h0C;
   localparam logic [7:0] OFS_OPPR = 8'h10;
   localparam logic [7:0] OFS_ODEN = 8'h14;
   localparam logic [7:0] OFS_STS  = 8'h18;
   localparam logic [7:0] OFS_MASK = 8'h1C;
   localparam logic [7:0] OFS_POS  = 8'h20;
   localparam logic [7:0] OFS_ENC  = 8'h24;
   localparam logic [7:0] OFS_OCNT = 8'h28;

   // control and status field positions
   localparam int CTL_FULL_CLOSED = 0;
   localparam int CTL_GEAR_EN     = 1;
   localparam int ST_MULT_ERR     = 0;
   localparam int ST_HYB_DEV      = 1;

   // values after reset
   localparam logic [1:0]  RST_CTRL = 2'h2;
   localparam logic [20:0] RST_PPR  = 21'h002710;
   localparam logic [30:0] RST_GNUM = 31'h00000000;
   localparam logic [30:0] RST_GDEN = 31'h00002710;
   localparam logic [18:0] RST_OPPR = 19'h009C4;
   localparam logic [18:0] RST_ODEN = 19'h00000;

   // setting limits and fixed figures
   localparam logic [20:0] MAX_PPR   = 21'h100000;
   localparam logic [30:0] MAX_GEAR  = 31'h40000000;
   localparam logic [18:0] MAX_OPPR  = 19'h40000;
   localparam logic [30:0] GEAR_ONE  = 31'h00000001;
   localparam logic [30:0] ENC_RES   = 31'h00100000;

   // a ratio handed to a pulse scaler
   typedef struct packed {
      logic [30:0] num;
      logic [30:0] den;
   } eg_ratio_s;

   // settings that only take effect after a power cycle
   typedef struct packed {
      logic [20:0] ppr;
      logic [18:0] oppr;
      logic [18:0] oden;
   } eg_cfg_s;

   localparam eg_cfg_s RST_CFG = '{ppr: RST_PPR, oppr: RST_OPPR,
                                   oden: RST_ODEN};

endpackage

// >>> core/eg_ratio_sel.sv
`timescale 1ns/1ps
`default_nettype none
module eg_ratio_sel
   import eg_pkg::*;
(
   input  wire logic        full_closed, // full-closed control mode
   input  wire logic [20:0] ppr,         // active pulses per revolution
   input  wire logic [30:0] gnum,        // gear numerator
   input  wire logic [30:0] gden,        // gear denominator
   output eg_ratio_s        ratio        // selected scale ratio
);

   logic [30:0] den_safe;

   // a zero denominator would never drain, so it acts as one
   assign den_safe = (gden == 31'h0) ? GEAR_ONE : gden;

   // ratio selection per control mode and setting combination
   always_comb
   begin
      ratio.num = gnum;     // [R03] [R05]
      ratio.den = den_safe; // [R03] [R05]
      if (full_closed)
      begin
         if (gnum == 31'h0)
         begin
            ratio.num = GEAR_ONE; // [R04]
            ratio.den = GEAR_ONE; // [R04]
         end
      end
      else if (ppr != 21'h0)
      begin
         ratio.num = ENC_RES;        // [R01]
         ratio.den = {10'h0, ppr};   // [R01]
      end
      else if (gnum == 31'h0)
      begin
         ratio.num = ENC_RES;        // [R02]
      end
   end

endmodule
`default_nettype wire

// >>> core/eg_step_gen.sv
`timescale 1ns/1ps
`default_nettype none
module eg_step_gen
   import eg_pkg::*;
(
   input  wire logic      clk,      // system clock
   input  wire logic      reset_n,  // synchronous reset, active low
   input  wire logic      in_evt,   // one input count, pulse
   input  wire logic      in_dir,   // direction of the input count
   input  wire eg_ratio_s ratio,    // num over den, den never zero
   output logic           step,     // one scaled output count, pulse
   output logic           step_dir, // direction of that count
   output logic           busy      // remainder still being drained
);

   logic signed [32:0] acc_q;
   logic signed [32:0] acc_d;
   logic signed [32:0] num_s;
   logic signed [32:0] den_s;
   logic               up;
   logic               dn;
   logic               take;

   assign num_s = signed'({2'b00, ratio.num});
   assign den_s = signed'({2'b00, ratio.den});
   assign up    = (acc_q >= den_s);
   assign dn    = (acc_q <= -den_s);
   assign busy  = up | dn;
   assign take  = in_evt & ~busy;

   // fractional accumulator: add num per input, drain den per step
   always_comb
   begin
      acc_d = acc_q;
      if (up)
         acc_d = acc_d - den_s;
      else if (dn)
         acc_d = acc_d + den_s;
      if (take)
         acc_d = in_dir ? (acc_d + num_s) : (acc_d - num_s);
   end

   // one output step per clock at most
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         acc_q    <= 33'sh0;
         step     <= 1'b0;
         step_dir <= 1'b0;
      end
      else
      begin
         acc_q    <= acc_d;
         step     <= busy;
         step_dir <= up;
      end
   end

endmodule
`default_nettype wire

// >>> core/eg_gear_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R01] position mode, nonzero pulses-per-rev: encoder resolution over it
// [R02] position mode, both zero: encoder resolution over gear denominator
// [R03] position mode, numerator nonzero: ratio numerator over denominator
// [R04] full-closed mode, numerator zero: pass pulses one to one
// [R05] full-closed, numerator nonzero: num over den, pulses-per-rev ignored
// [R06] software keeps the ratio between one thousandth and one thousand
// [R07] too high a ratio for the pulse rate raises multiplication error
// [R08] changing the gear in full-closed mode raises hybrid deviation alarm
// [R09] output pulses per rev accepted 0 to 262144, default 2500
// [R10] nonzero output divider: encoder counts scaled by pulses over divider
// [R11] zero output divider: four times output pulses edges per revolution
// [R12] power-up settings take effect only at the next reset
module eg_gear_top
   import eg_pkg::*;
(
   input  wire logic        clk,            // 40 MHz system clock
   input  wire logic        reset_n,        // control power reset, low
   input  wire logic        store_reset_n,  // settings store reset, low
   input  wire logic [7:0]  paddr,          // apb address
   input  wire logic        psel,           // apb select
   input  wire logic        penable,        // apb enable
   input  wire logic        pwrite,         // apb write
   input  wire logic [31:0] pwdata,         // apb write data
   output logic      [31:0] prdata,         // apb read data
   output logic             pready,         // apb ready
   output logic             pslverr,        // apb error
   input  wire logic        cmd_pulse,      // command pulse pin
   input  wire logic        cmd_dir,        // command direction pin
   input  wire logic        enc_pulse,      // encoder count pin
   input  wire logic        enc_dir,        // encoder direction pin
   output logic             pos_step,       // positional command step
   output logic             pos_dir,        // positional command dir
   output logic             output_phase_a, // reproduced phase a
   output logic             output_phase_b, // reproduced phase b
   output logic             irq             // level interrupt
);

   logic [3:0]  pin_s1_q;
   logic [3:0]  pin_s2_q;
   logic [3:0]  pin_s3_q;
   logic        cmd_evt;
   logic        enc_evt;
   logic [1:0]  ctrl_q;
   eg_cfg_s     pend_q;
   eg_cfg_s     act_q;
   logic [30:0] gnum_q;
   logic [30:0] gden_q;
   logic [1:0]  sts_q;
   logic [1:0]  sts_set;
   logic [1:0]  sts_clr;
   logic [1:0]  mask_q;
   logic [31:0] pos_q;
   logic [31:0] ocnt_q;
   logic        wr_en;
   logic        rd_phase;
   logic [31:0] rd_d;
   logic        err_d;
   logic        gear_chg;
   eg_ratio_s   gear_r;
   eg_ratio_s   out_r;
   logic        g_step;
   logic        g_dir;
   logic        g_busy;
   logic        o_step;
   logic        o_dir;
   logic        o_busy;

   // clamp a written word to an upper limit
   function automatic logic [30:0] clamp(input logic [31:0] v,
                                         input logic [30:0] lim);
      clamp = (v > {1'b0, lim}) ? lim : v[30:0];
   endfunction

   // next quadrature state, a leads b when moving forward
   function automatic logic [1:0] quad_next(input logic [1:0] ab,
                                            input logic       fwd);
      quad_next = fwd ? {~ab[0], ab[1]} : {ab[0], ~ab[1]};
   endfunction

   // two-stage synchroniser, then an edge stage for the pulses
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pin_s1_q <= 4'h0;
         pin_s2_q <= 4'h0;
         pin_s3_q <= 4'h0;
      end
      else
      begin
         pin_s1_q <= {enc_dir, enc_pulse, cmd_dir, cmd_pulse};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   assign cmd_evt = pin_s2_q[0] & ~pin_s3_q[0] & ctrl_q[CTL_GEAR_EN];
   assign enc_evt = pin_s2_q[2] & ~pin_s3_q[2];

   // apb decode, one wait state before every answer
   assign rd_phase = psel & penable & ~pready;
   assign wr_en    = psel & penable & pready & pwrite;

   always_comb
   begin
      rd_d  = 32'h0;
      err_d = 1'b0;
      case (paddr)
         OFS_CTRL: rd_d = {30'h0, ctrl_q};
         OFS_PPR:  rd_d = {11'h0, pend_q.ppr};
         OFS_GNUM: rd_d = {1'h0, gnum_q};
         OFS_GDEN: rd_d = {1'h0, gden_q};
         OFS_OPPR: rd_d = {13'h0, pend_q.oppr};
         OFS_ODEN: rd_d = {13'h0, pend_q.oden};
         OFS_STS:  rd_d = {30'h0, sts_q};
         OFS_MASK: rd_d = {30'h0, mask_q};
         OFS_POS:  rd_d = pos_q;
         OFS_ENC:  rd_d = {1'h0, ENC_RES};
         OFS_OCNT: rd_d = ocnt_q;
         default:  err_d = 1'b1;
      endcase
   end

   // apb answer flops
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= rd_phase;
         prdata  <= (rd_phase && !pwrite) ? rd_d : 32'h0;
         pslverr <= rd_phase & err_d;
      end
   end

   // control, gear and mask registers, immediate effect
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         ctrl_q <= RST_CTRL;
         gnum_q <= RST_GNUM;
         gden_q <= RST_GDEN;
         mask_q <= 2'h0;
      end
      else if (wr_en)
      begin
         if (paddr == OFS_CTRL)
            ctrl_q <= pwdata[1:0];
         if (paddr == OFS_GNUM)
            gnum_q <= clamp(pwdata, MAX_GEAR);
         if (paddr == OFS_GDEN)
            gden_q <= clamp(pwdata, MAX_GEAR);
         if (paddr == OFS_MASK)
            mask_q <= pwdata[1:0];
      end
   end

   // power-up settings store, survives control resets
   always_ff @(posedge clk)
   begin
      if (!store_reset_n)
         pend_q <= RST_CFG;
      else if (wr_en)
      begin
         if (paddr == OFS_PPR)
            pend_q.ppr <= 21'(clamp(pwdata, {10'h0, MAX_PPR}));
         if (paddr == OFS_OPPR)
            pend_q.oppr <= 19'(clamp(pwdata, {12'h0, MAX_OPPR})); // [R09]
         if (paddr == OFS_ODEN)
            pend_q.oden <= 19'(clamp(pwdata, {12'h0, MAX_OPPR}));
      end
   end

   // active copy is loaded only while reset is held
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         act_q <= pend_q; // [R12]
   end

   // gear change while in full-closed control
   assign gear_chg = wr_en & ctrl_q[CTL_FULL_CLOSED]
      & (((paddr == OFS_GNUM) && (clamp(pwdata, MAX_GEAR) != gnum_q))
      || ((paddr == OFS_GDEN) && (clamp(pwdata, MAX_GEAR) != gden_q)));

   // sticky events, a set in the clear cycle wins
   assign sts_set[ST_MULT_ERR] = cmd_evt & g_busy; // [R07]
   assign sts_set[ST_HYB_DEV]  = gear_chg;         // [R08]
   assign sts_clr = (wr_en && paddr == OFS_STS) ? pwdata[1:0] : 2'h0;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
         sts_q <= 2'h0;
      else
         sts_q <= (sts_q & ~sts_clr) | sts_set;
   end

   // interrupt level from unmasked status
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         irq <= 1'b0;
      else
         irq <= |(sts_q & ~mask_q);
   end

   // electronic gear ratio select
   eg_ratio_sel u_gear_sel (
      .full_closed (ctrl_q[CTL_FULL_CLOSED]),
      .ppr         (act_q.ppr),
      .gnum        (gnum_q),
      .gden        (gden_q),
      .ratio       (gear_r)
   );

   // command pulse scaler, busy input pulses are dropped
   eg_step_gen u_gear (
      .clk      (clk),
      .reset_n  (reset_n),
      .in_evt   (cmd_evt),
      .in_dir   (pin_s2_q[1]),
      .ratio    (gear_r),
      .step     (g_step),
      .step_dir (g_dir),
      .busy     (g_busy)
   );

   // positional command output and counter
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pos_step <= 1'b0;
         pos_dir  <= 1'b0;
         pos_q    <= 32'h0;
      end
      else
      begin
         pos_step <= g_step;
         pos_dir  <= g_dir;
         if (g_step)
            pos_q <= g_dir ? pos_q + 32'h1 : pos_q - 32'h1;
      end
   end

   // output divider ratio from the active settings
   always_comb
   begin
      if (act_q.oden != 19'h0)
      begin
         out_r.num = {12'h0, act_q.oppr}; // [R10]
         out_r.den = {12'h0, act_q.oden}; // [R10]
      end
      else
      begin
         out_r.num = {10'h0, act_q.oppr, 2'b00}; // [R11]
         out_r.den = ENC_RES;                    // [R11]
      end
   end

   // encoder feedback divider
   eg_step_gen u_out (
      .clk      (clk),
      .reset_n  (reset_n),
      .in_evt   (enc_evt),
      .in_dir   (pin_s2_q[3]),
      .ratio    (out_r),
      .step     (o_step),
      .step_dir (o_dir),
      .busy     (o_busy)
   );

   // quadrature reproduction, one edge per divided count
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         output_phase_a <= 1'b0;
         output_phase_b <= 1'b0;
         ocnt_q         <= 32'h0;
      end
      else if (o_step)
      begin
         {output_phase_a, output_phase_b} <=
            quad_next({output_phase_a, output_phase_b}, o_dir);
         ocnt_q <= ocnt_q + 32'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_ratio_ppr: assert property (!ctrl_q[0] && act_q.ppr != 21'h0 |-> // [R01]
      gear_r.num == ENC_RES && gear_r.den == {10'h0, act_q.ppr})
      else $error("ppr ratio wrong");
   a_ratio_encden: assert property (act_q.ppr == 21'h0 && // [R02]
      !ctrl_q[0] && gnum_q == 31'h0 && gden_q != 31'h0 |->
      gear_r.num == ENC_RES && gear_r.den == gden_q)
      else $error("encoder over denominator ratio wrong");
   a_ratio_frac: assert property (act_q.ppr == 21'h0 && // [R03]
      !ctrl_q[0] && gnum_q != 31'h0 && gden_q != 31'h0 |->
      gear_r.num == gnum_q && gear_r.den == gden_q)
      else $error("fraction ratio wrong");
   a_fc_unity: assert property (ctrl_q[0] && gnum_q == 31'h0 |-> // [R04]
      gear_r.num == GEAR_ONE && gear_r.den == GEAR_ONE)
      else $error("full-closed unity ratio wrong");
   a_fc_frac: assert property (ctrl_q[0] && gnum_q != 31'h0 && // [R05]
      gden_q != 31'h0 |-> gear_r == {gnum_q, gden_q})
      else $error("full-closed ratio wrong");
   a_mult_flag: assert property (cmd_evt && g_busy |=> // [R07]
      sts_q[ST_MULT_ERR] ##1 irq == !mask_q[ST_MULT_ERR] || sts_q[1])
      else $error("multiplication error not raised");
   a_hyb_flag: assert property (gear_chg |=> sts_q[ST_HYB_DEV]) // [R08]
      else $error("hybrid alarm not raised");
   a_oppr_range: assert property (pend_q.oppr <= MAX_OPPR) // [R09]
      else $error("output pulses out of range");
   a_div_ratio: assert property (act_q.oden != 19'h0 |-> // [R10]
      out_r == {12'h0, act_q.oppr, 12'h0, act_q.oden})
      else $error("output divider ratio wrong");
   a_quad_edge: assert property (o_step |=> // [R11]
      $countones({output_phase_a, output_phase_b} ^
      $past({output_phase_a, output_phase_b})) == 1)
      else $error("quadrature edge not single");
   a_cfg_hold: assert property ($past(reset_n) |-> $stable(act_q)) // [R12]
      else $error("power-up setting changed while running");

   c_mult_err: cover property ($rose(sts_q[ST_MULT_ERR]));
   c_hyb_dev:  cover property ($rose(sts_q[ST_HYB_DEV]));
   c_pos_run:  cover property (pos_step [*3]);
   c_quad_out: cover property ($rose(output_phase_a));

endmodule
`default_nettype wire

// >>> verif/eg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module eg_host_model (
   input  wire logic clk,            // system clock
   input  wire logic pos_step,       // scaled command step
   input  wire logic pos_dir,        // scaled command direction
   input  wire logic output_phase_a, // reproduced phase a
   input  wire logic output_phase_b, // reproduced phase b
   output logic      cmd_pulse,      // command pulse pin
   output logic      cmd_dir,        // command direction pin
   output logic      enc_pulse,      // encoder count pin
   output logic      enc_dir         // encoder direction pin
);
   int   step_cnt;
   int   edge_cnt;
   int   quad_err;
   logic a_q;
   logic b_q;

   // pulse pins idle low, direction pins idle high, tallies empty
   initial
   begin
      cmd_pulse = 1'b0;
      cmd_dir   = 1'b1;
      enc_pulse = 1'b0;
      enc_dir   = 1'b1;
      step_cnt  = 0;
      edge_cnt  = 0;
      quad_err  = 0;
      a_q       = 1'b0;
      b_q       = 1'b0;
   end

   // signed step tally, phase edge tally, a must lead b going forward
   always @(posedge clk)
   begin
      if (pos_step === 1'b1)
         step_cnt <= step_cnt + ((pos_dir === 1'b1) ? 1 : -1);
      if (output_phase_a !== a_q || output_phase_b !== b_q)
         edge_cnt <= edge_cnt + 1;
      if (output_phase_a === 1'b1 && a_q === 1'b0 && output_phase_b !== 1'b0)
         quad_err <= quad_err + 1;
      a_q <= output_phase_a;
      b_q <= output_phase_b;
   end

   // n one-cycle pulses on one pin; the caller picks the spacing
   task automatic send(input logic enc, input logic dir, input int n,
                       input int gap);
      @(posedge clk);
      cmd_dir <= dir;
      enc_dir <= dir;
      repeat (n)
      begin
         @(posedge clk);
         if (enc)
            enc_pulse <= 1'b1;
         else
            cmd_pulse <= 1'b1;
         @(posedge clk);
         cmd_pulse <= 1'b0;
         enc_pulse <= 1'b0;
         repeat (gap - 2) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// >>> verif/eg_gear_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eg_gear_top_tb;
   import eg_pkg::*;
   logic        clk;
   logic        reset_n;
   logic        store_reset_n;
   logic [7:0]  paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cmd_pulse;
   logic        cmd_dir;
   logic        enc_pulse;
   logic        enc_dir;
   logic        pos_step;
   logic        pos_dir;
   logic        output_phase_a;
   logic        output_phase_b;
   logic        irq;
   logic [31:0] rd;
   logic        er;
   int          err_count;
   int          check_count;

   eg_gear_top eg_gear_top_i (.clk, .reset_n, .store_reset_n, .paddr, .psel,
      .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .cmd_pulse,
      .cmd_dir, .enc_pulse, .enc_dir, .pos_step, .pos_dir, .output_phase_a,
      .output_phase_b, .irq);
   eg_host_model eg_host_model_i (.clk, .pos_step, .pos_dir, .output_phase_a,
      .output_phase_b, .cmd_pulse, .cmd_dir, .enc_pulse, .enc_dir);

   // 25 ns clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t value %0h want %0h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH %0t flag %b want %b", $time, got, exp);
      end
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         err_count++;
         $display("MISMATCH %0t apb timeout", $time);
         report_and_stop();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk_val(rd, exp);
      chk_bit(er, 1'b0);
   endtask

   task automatic power_cycle;
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
   endtask

   // command pulses in, count the scaled steps once drained
   task automatic run_cmd(input logic dir, input int n, input int gap,
                          input int exp);
      eg_host_model_i.step_cnt = 0;
      eg_host_model_i.send(1'b0, dir, n, gap);
      repeat (300) @(posedge clk);
      chk_val(32'(eg_host_model_i.step_cnt), 32'(exp));
   endtask

   task automatic run_enc(input int n, input int exp);
      eg_host_model_i.send(1'b1, 1'b1, n, 3);
      repeat (50) @(posedge clk);
      chk_val(32'(eg_host_model_i.edge_cnt), 32'(exp));
      chk_val(32'(eg_host_model_i.quad_err), 32'h00000000);
   endtask

   task automatic test_regs;
      rdchk(OFS_CTRL, 32'h00000002);
      rdchk(OFS_PPR, 32'h00002710);
      rdchk(OFS_GNUM, 32'h00000000);
      rdchk(OFS_GDEN, 32'h00002710);
      rdchk(OFS_OPPR, 32'h000009C4);
      rdchk(OFS_ODEN, 32'h00000000);
      wr(OFS_ENC, 32'h00000005);
      rdchk(OFS_ENC, 32'h00100000);
      wr(OFS_OPPR, 32'h0007FFFF);
      rdchk(OFS_OPPR, 32'h00040000);
      wr(OFS_OPPR, 32'h000009C4);
      apb(1'b0, 8'h30, 32'h00000000);
      chk_bit(er, 1'b1);
      chk_val(rd, 32'h00000000);
      $display("test regs done");
   endtask

   task automatic test_full_closed;
      wr(OFS_CTRL, 32'h00000003);
      run_cmd(1'b1, 10, 8, 10);
      run_cmd(1'b0, 10, 8, -10);
      rdchk(OFS_STS, 32'h00000000);
      wr(OFS_GNUM, 32'h00000005);
      rdchk(OFS_STS, 32'h00000002);
      chk_bit(irq, 1'b1);
      wr(OFS_GDEN, 32'h00000002);
      run_cmd(1'b1, 10, 8, 25);
      wr(OFS_MASK, 32'h00000002);
      repeat (2) @(posedge clk);
      chk_bit(irq, 1'b0);
      wr(OFS_STS, 32'h00000002);
      rdchk(OFS_STS, 32'h00000000);
      wr(OFS_MASK, 32'h00000000);
      wr(OFS_CTRL, 32'h00000002);
      $display("test full closed done");
   endtask

   task automatic test_position;
      wr(OFS_GNUM, 32'h00000003);
      wr(OFS_GDEN, 32'h00000002);
      wr(OFS_PPR, 32'h00000000);
      run_cmd(1'b1, 20, 120, 2097);
      power_cycle();
      wr(OFS_GDEN, 32'h00080000);
      run_cmd(1'b1, 10, 8, 20);
      wr(OFS_GNUM, 32'h00000003);
      wr(OFS_GDEN, 32'h00000002);
      run_cmd(1'b1, 10, 8, 15);
      rdchk(OFS_STS, 32'h00000000);
      wr(OFS_GNUM, 32'h000003E8);
      wr(OFS_GDEN, 32'h00000001);
      eg_host_model_i.send(1'b0, 1'b1, 3, 4);
      repeat (1100) @(posedge clk);
      rdchk(OFS_STS, 32'h00000001);
      chk_bit(irq, 1'b1);
      wr(OFS_STS, 32'h00000001);
      rdchk(OFS_STS, 32'h00000000);
      $display("test position done");
   endtask

   task automatic test_encoder;
      eg_host_model_i.edge_cnt = 0;
      run_enc(1049, 10);
      wr(OFS_ODEN, 32'h00000004);
      wr(OFS_OPPR, 32'h00000001);
      run_enc(40, 10);
      power_cycle();
      repeat (4) @(posedge clk);
      eg_host_model_i.edge_cnt = 0;
      run_enc(40, 10);
      $display("test encoder done");
   endtask

   // reset both stores, then the scenarios in turn
   initial
   begin
      reset_n       = 1'b0;
      store_reset_n = 1'b0;
      paddr         = 8'h00;
      psel          = 1'b0;
      penable       = 1'b0;
      pwrite        = 1'b0;
      pwdata        = 32'h00000000;
      err_count     = 0;
      check_count   = 0;
      repeat (15) @(posedge clk);
      store_reset_n <= 1'b1;
      @(posedge clk);
      reset_n <= 1'b1;
      test_regs();
      test_full_closed();
      test_position();
      test_encoder();
      report_and_stop();
   end
endmodule
`default_nettype wire
